// File: hw/dcf_pkg.sv
// Constants for the disk-change force register and the two mirror registers.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package dcf_pkg;
    // ==========================================================
    // Register indices and byte addresses
    localparam int DCF_ADDR_W = 8;
    localparam logic [7:0] DCF_IDX_FORCE = 8'h1e;
    localparam logic [7:0] DCF_IDX_RATE = 8'h1f;
    localparam logic [7:0] DCF_IDX_FIFO = 8'h20;
    localparam logic [DCF_ADDR_W-1:0] DCF_ADDR_FORCE = DCF_ADDR_W'({DCF_IDX_FORCE, 2'b00});
    localparam logic [DCF_ADDR_W-1:0] DCF_ADDR_RATE = DCF_ADDR_W'({DCF_IDX_RATE, 2'b00});
    localparam logic [DCF_ADDR_W-1:0] DCF_ADDR_FIFO = DCF_ADDR_W'({DCF_IDX_FIFO, 2'b00});

    // ==========================================================
    // Field positions
    localparam int DCF_FC0_BIT = 0;
    localparam int DCF_FC1_BIT = 1;
    localparam int DCF_RATE_RSVD_BIT = 5;
    localparam int DCF_FIFO_RSVD_LO = 4;
    localparam int DCF_FIFO_RSVD_HI = 5;

    // ==========================================================
    // Reset values
    localparam logic [1:0] DCF_FORCE_RST = 2'h3;
    localparam logic [7:0] DCF_RATE_RST = 8'h02;
    localparam logic [7:0] DCF_FIFO_RST = 8'h00;

    // ==========================================================
    // Bus responses
    localparam logic [1:0] DCF_RESP_OKAY = 2'h0;
    localparam logic [1:0] DCF_RESP_SLVERR = 2'h2;
endpackage

// File: hw/dcf_axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight at a time.
// Assumes the register file decodes combinationally in the same cycle.
module dcf_axil_slave
    import dcf_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Write address and data
    input wire logic [DCF_ADDR_W-1:0] s_awaddr_in,
    input wire logic s_awvalid_in,
    output logic s_awready_out,
    input wire logic [31:0] s_wdata_in,
    input wire logic [3:0] s_wstrb_in,
    input wire logic s_wvalid_in,
    output logic s_wready_out,
    // Write response
    output logic [1:0] s_bresp_out,
    output logic s_bvalid_out,
    input wire logic s_bready_in,
    // Read address and data
    input wire logic [DCF_ADDR_W-1:0] s_araddr_in,
    input wire logic s_arvalid_in,
    output logic s_arready_out,
    output logic [31:0] s_rdata_out,
    output logic [1:0] s_rresp_out,
    output logic s_rvalid_out,
    input wire logic s_rready_in,
    // Register file side
    output logic wr_en_out,
    output logic [DCF_ADDR_W-1:0] wr_addr_out,
    output logic [31:0] wr_data_out,
    output logic [3:0] wr_strb_out,
    input wire logic wr_ok_in,
    output logic rd_en_out,
    output logic [DCF_ADDR_W-1:0] rd_addr_out,
    input wire logic [31:0] rd_data_in,
    input wire logic rd_ok_in
);
    typedef struct packed {
        logic aw_held;
        logic [DCF_ADDR_W-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dcf_axs_t;

    dcf_axs_t st;
    dcf_axs_t next_st;

    // ==========================================================
    // Handshakes
    assign s_awready_out = !st.aw_held && !st.bvalid;
    assign s_wready_out = !st.w_held && !st.bvalid;
    assign s_arready_out = !st.rvalid;
    assign s_bvalid_out = st.bvalid;
    assign s_bresp_out = st.bresp;
    assign s_rvalid_out = st.rvalid;
    assign s_rdata_out = st.rdata;
    assign s_rresp_out = st.rresp;
    assign wr_en_out = st.aw_held && st.w_held && !st.bvalid;
    assign wr_addr_out = st.awaddr;
    assign wr_data_out = st.wdata;
    assign wr_strb_out = st.wstrb;
    assign rd_en_out = s_arvalid_in && !st.rvalid;
    assign rd_addr_out = s_araddr_in;

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        if (s_awvalid_in && s_awready_out) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = s_awaddr_in;
        end
        if (s_wvalid_in && s_wready_out) begin
            next_st.w_held = 1'b1;
            next_st.wdata = s_wdata_in;
            next_st.wstrb = s_wstrb_in;
        end
        if (wr_en_out) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_ok_in ? DCF_RESP_OKAY : DCF_RESP_SLVERR;
        end
        if (st.bvalid && s_bready_in) begin
            next_st.bvalid = 1'b0;
        end
        if (rd_en_out) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_ok_in ? rd_data_in : 32'h0000_0000;
            next_st.rresp = rd_ok_in ? DCF_RESP_OKAY : DCF_RESP_SLVERR;
        end else if (st.rvalid && s_rready_in) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// File: hw/dcf_regs.sv
// Disk-change force register and read-only mirrors of two write-only registers.
// Assumes the floppy core and first serial port report their writes on clk_in.
// Notes on behaviour
// - Software writing one sets a force bit, writing zero leaves it alone.
// - Step active with drive-one select active clears the drive-one force bit.
// - Step active with drive-zero select active clears the drive-zero force bit.
// - The disk-change flag is the OR of both selected force terms and the changed input.
// - A force bit makes the change appear only while its own drive is selected.
// - Bit 0 of the force register controls drive zero, one meaning active.
// - Bit 1 of the force register controls drive one, one meaning active.
// - Bits 7 to 2 of the force register always read zero.
// - The force register resets to 0x03 on main reset.
// - Bits 1 and 0 of the rate mirror follow the data-rate select bits.
// - Bits 4 to 2 of the rate mirror follow precompensation, bit 5 reads zero.
// - Bit 6 of the rate mirror follows power-down and bit 7 soft reset.
// - The rate mirror resets to 0x02 on main and standby reset.
// - The fifo mirror shows receive reset, transmit reset and dma mode in bits 1 to 3.
// - The fifo mirror resets to 0x00 on main and standby reset.
// - The fifo mirror shows enable in bit 0, trigger level in bits 7 and 6, zero in 5 and 4.
module dcf_regs
    import dcf_pkg::*;
(
    // Clock and resets
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic standby_power_on_reset_in,
    // AXI4-Lite write address and data
    input wire logic [DCF_ADDR_W-1:0] s_awaddr_in,
    input wire logic s_awvalid_in,
    output logic s_awready_out,
    input wire logic [31:0] s_wdata_in,
    input wire logic [3:0] s_wstrb_in,
    input wire logic s_wvalid_in,
    output logic s_wready_out,
    // AXI4-Lite write response
    output logic [1:0] s_bresp_out,
    output logic s_bvalid_out,
    input wire logic s_bready_in,
    // AXI4-Lite read
    input wire logic [DCF_ADDR_W-1:0] s_araddr_in,
    input wire logic s_arvalid_in,
    output logic s_arready_out,
    output logic [31:0] s_rdata_out,
    output logic [1:0] s_rresp_out,
    output logic s_rvalid_out,
    input wire logic s_rready_in,
    // Drive pins
    input wire logic step_pulse_n_in,
    input wire logic drive0_select_n_in,
    input wire logic drive1_select_n_in,
    input wire logic disk_changed_in_n_in,
    // Source register writes
    input wire logic rate_wr_in,
    input wire logic [7:0] rate_data_in,
    input wire logic fifo_ctrl_wr_in,
    input wire logic [7:0] fifo_ctrl_data_in,
    // Status to the floppy core
    output logic disk_change_flag_out,
    output logic [1:0] force_state_out
);
    typedef struct packed {
        logic [1:0] step_n;
        logic [1:0] ds0_n;
        logic [1:0] ds1_n;
        logic [1:0] chg_n;
        logic [1:0] force_disk_change_ctrl;
        logic [7:0] floppy_rate_mirror;
        logic [7:0] serial1_fifo_ctrl_mirror;
        logic flag;
    } dcf_regs_t;

    dcf_regs_t st;
    dcf_regs_t next_st;

    logic wr_en;
    logic [DCF_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_en;
    logic [DCF_ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [1:0] sel;
    logic [1:0] clr;
    logic [1:0] set;

    // ==========================================================
    // Bus front end
    dcf_axil_slave u_bus (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .s_awaddr_in(s_awaddr_in),
        .s_awvalid_in(s_awvalid_in),
        .s_awready_out(s_awready_out),
        .s_wdata_in(s_wdata_in),
        .s_wstrb_in(s_wstrb_in),
        .s_wvalid_in(s_wvalid_in),
        .s_wready_out(s_wready_out),
        .s_bresp_out(s_bresp_out),
        .s_bvalid_out(s_bvalid_out),
        .s_bready_in(s_bready_in),
        .s_araddr_in(s_araddr_in),
        .s_arvalid_in(s_arvalid_in),
        .s_arready_out(s_arready_out),
        .s_rdata_out(s_rdata_out),
        .s_rresp_out(s_rresp_out),
        .s_rvalid_out(s_rvalid_out),
        .s_rready_in(s_rready_in),
        .wr_en_out(wr_en),
        .wr_addr_out(wr_addr),
        .wr_data_out(wr_data),
        .wr_strb_out(wr_strb),
        .wr_ok_in(wr_ok),
        .rd_en_out(rd_en),
        .rd_addr_out(rd_addr),
        .rd_data_in(rd_data),
        .rd_ok_in(rd_ok)
    );

    // ==========================================================
    // Decode
    assign wr_ok = (wr_addr == DCF_ADDR_FORCE) || (wr_addr == DCF_ADDR_RATE)
        || (wr_addr == DCF_ADDR_FIFO);
    assign rd_ok = wr_ok_rd(rd_addr);

    function automatic logic wr_ok_rd(input logic [DCF_ADDR_W-1:0] a);
        wr_ok_rd = (a == DCF_ADDR_FORCE) || (a == DCF_ADDR_RATE) || (a == DCF_ADDR_FIFO);
    endfunction

    // ==========================================================
    // Read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        if (rd_en) begin
            case (rd_addr)
                DCF_ADDR_FORCE: rd_data = {30'h0000_0000, st.force_disk_change_ctrl};
                DCF_ADDR_RATE: rd_data = {24'h00_0000, st.floppy_rate_mirror};
                DCF_ADDR_FIFO: rd_data = {24'h00_0000, st.serial1_fifo_ctrl_mirror};
                default: rd_data = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Force bits, set wins over clear
    assign sel = {~st.ds1_n[1], ~st.ds0_n[1]};
    assign clr[DCF_FC0_BIT] = ~(st.step_n[1] | st.ds0_n[1]);
    assign clr[DCF_FC1_BIT] = ~(st.step_n[1] | st.ds1_n[1]);
    assign set = (wr_en && wr_strb[0] && wr_addr == DCF_ADDR_FORCE)
        ? wr_data[1:0] : 2'h0;

    always_comb begin
        next_st = st;
        // Pin synchronisers
        next_st.step_n = {st.step_n[0], step_pulse_n_in};
        next_st.ds0_n = {st.ds0_n[0], drive0_select_n_in};
        next_st.ds1_n = {st.ds1_n[0], drive1_select_n_in};
        next_st.chg_n = {st.chg_n[0], disk_changed_in_n_in};
        // Zero writes leave force bits alone
        next_st.force_disk_change_ctrl = set | (st.force_disk_change_ctrl & ~clr);
        // Flag seen by the floppy core
        next_st.flag = |(sel & st.force_disk_change_ctrl) | ~st.chg_n[1];
        // Mirrors follow source writes, never bus writes; standby reset reloads them and wins over a source write
        if (rate_wr_in) begin
            next_st.floppy_rate_mirror = rate_data_in;
            next_st.floppy_rate_mirror[DCF_RATE_RSVD_BIT] = 1'b0;
        end
        if (fifo_ctrl_wr_in) begin
            next_st.serial1_fifo_ctrl_mirror = fifo_ctrl_data_in;
            next_st.serial1_fifo_ctrl_mirror[DCF_FIFO_RSVD_HI:DCF_FIFO_RSVD_LO] = 2'h0;
        end
        if (standby_power_on_reset_in) begin
            next_st.floppy_rate_mirror = DCF_RATE_RST;
            next_st.serial1_fifo_ctrl_mirror = DCF_FIFO_RST;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '0;
            st.step_n <= 2'h3;
            st.ds0_n <= 2'h3;
            st.ds1_n <= 2'h3;
            st.chg_n <= 2'h3;
            st.force_disk_change_ctrl <= DCF_FORCE_RST;
            st.floppy_rate_mirror <= DCF_RATE_RST;
            st.serial1_fifo_ctrl_mirror <= DCF_FIFO_RST;
        end else begin
            st <= next_st;
        end
    end

    assign disk_change_flag_out = st.flag;
    assign force_state_out = st.force_disk_change_ctrl;
endmodule

// File: bench/dcf_regs_properties.sv
// Port checker for dcf_regs, bound at the foot of this file.
// Assumes one clock and a synchronous active-high reset.
module dcf_regs_properties
    import dcf_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Bus handshakes
    input wire logic s_awvalid_in,
    input wire logic s_awready_out,
    input wire logic s_wvalid_in,
    input wire logic s_wready_out,
    input wire logic s_bvalid_out,
    input wire logic s_arvalid_in,
    input wire logic s_arready_out,
    input wire logic s_rvalid_out,
    // Drive pins and status
    input wire logic step_pulse_n_in,
    input wire logic drive0_select_n_in,
    input wire logic drive1_select_n_in,
    input wire logic disk_changed_in_n_in,
    input wire logic disk_change_flag_out,
    input wire logic [1:0] force_state_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Cycles since a step on each drive
    logic [2:0] since0;
    logic [2:0] since1;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            since0 <= 3'h7;
            since1 <= 3'h7;
        end else begin
            since0 <= !(step_pulse_n_in | drive0_select_n_in) ? 3'h0 : since0 + 3'(since0 != 3'h7);
            since1 <= !(step_pulse_n_in | drive1_select_n_in) ? 3'h0 : since1 + 3'(since1 != 3'h7);
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_no_drive;
        drive0_select_n_in && drive1_select_n_in && disk_changed_in_n_in;
    endsequence
    sequence s_drive0_only;
        !drive0_select_n_in && drive1_select_n_in && step_pulse_n_in;
    endsequence
    sequence s_wr_taken;
        s_awvalid_in && s_awready_out && s_wvalid_in && s_wready_out;
    endsequence
    // ==========
    // Properties
    a_reset_force: assert property (
        disable iff (1'b0) rst_in |=> force_state_out == DCF_FORCE_RST) else $error("force reset");
    a_flag_idle: assert property (s_no_drive [*4] |=> !disk_change_flag_out)
        else $error("flag without cause");
    a_flag_changed: assert property (
        (!disk_changed_in_n_in) [*4] |=> disk_change_flag_out) else $error("flag missed change");
    a_flag_force: assert property (
        s_drive0_only [*4] ##0 force_state_out[0] |=> disk_change_flag_out) else $error("force lost");
    a_clear_drive0: assert property (
        $fell(force_state_out[0]) |-> since0 <= 3'h4) else $error("drive0 bit cleared alone");
    a_clear_drive1: assert property (
        $fell(force_state_out[1]) |-> since1 <= 3'h4) else $error("drive1 bit cleared alone");
    a_write_answer: assert property (s_wr_taken |-> ##2 s_bvalid_out) else $error("no write answer");
    a_read_answer: assert property (s_arvalid_in && s_arready_out |=> s_rvalid_out)
        else $error("no read answer");
    a_resp_blocks_aw: assert property (s_bvalid_out |-> !s_awready_out) else $error("aw taken");
endmodule

bind dcf_regs dcf_regs_properties i_dcf_regs_properties (.clk_in, .rst_in, .s_awvalid_in,
    .s_awready_out, .s_wvalid_in, .s_wready_out, .s_bvalid_out, .s_arvalid_in, .s_arready_out,
    .s_rvalid_out, .step_pulse_n_in, .drive0_select_n_in, .drive1_select_n_in,
    .disk_changed_in_n_in, .disk_change_flag_out, .force_state_out);

// File: bench/dcf_floppy_model.sv
// Floppy side model: drive selects, step pulses, media change, rate writes.
// Assumes its tasks are called from the bench just after a rising edge.
module dcf_floppy_model (
    // Clock
    input wire logic clk_in,
    // Drive pins, idle high
    output logic step_n_out,
    output logic sel0_n_out,
    output logic sel1_n_out,
    output logic changed_n_out,
    // Data-rate register writes
    output logic rate_wr_out,
    output logic [7:0] rate_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {step_n_out, sel0_n_out, sel1_n_out, changed_n_out} = 4'hf;
        rate_wr_out = 1'b0;
        rate_data_out = 8'h00;
    end
    task automatic select(input int d, input logic on);
        @(posedge clk_in);
        if (d == 0) begin
            sel0_n_out <= !on;
        end else begin
            sel1_n_out <= !on;
        end
        repeat (5) @(posedge clk_in);
    endtask
    task automatic step(input int len);
        @(posedge clk_in);
        step_n_out <= 1'b0;
        repeat (len) @(posedge clk_in);
        step_n_out <= 1'b1;
        repeat (5) @(posedge clk_in);
    endtask
    task automatic media(input logic gone);
        @(posedge clk_in);
        changed_n_out <= !gone;
        repeat (5) @(posedge clk_in);
    endtask
    task automatic rate(input logic [7:0] v);
        @(posedge clk_in);
        rate_wr_out <= 1'b1;
        rate_data_out <= v;
        @(posedge clk_in);
        rate_wr_out <= 1'b0;
        rate_data_out <= ~v;
    endtask
endmodule

// File: bench/tb_dcf_regs.sv
// Self-checking bench for dcf_regs over AXI4-Lite.
// Assumes the checker and the floppy model are compiled first.
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_dcf_regs
    import dcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, rst_in = 1'b1, standby_power_on_reset_in = 1'b0;
    logic [DCF_ADDR_W-1:0] s_awaddr_in = '0, s_araddr_in = '0;
    logic [31:0] s_wdata_in = '0, s_rdata_out;
    logic [3:0] s_wstrb_in = 4'h0;
    logic s_awvalid_in = 1'b0, s_wvalid_in = 1'b0, s_arvalid_in = 1'b0;
    logic s_bready_in = 1'b0, s_rready_in = 1'b0, fifo_ctrl_wr_in = 1'b0;
    logic [7:0] fifo_ctrl_data_in = 8'h00, rate_data_in;
    logic s_awready_out, s_wready_out, s_bvalid_out, s_arready_out, s_rvalid_out;
    logic [1:0] s_bresp_out, s_rresp_out, force_state_out;
    logic step_pulse_n_in, drive0_select_n_in, drive1_select_n_in, disk_changed_in_n_in;
    logic rate_wr_in, disk_change_flag_out;
    logic [7:0] pats [3] = '{8'hff, 8'h5a, 8'ha5};
    int errors = 0, check_count = 0, cycles = 0;
    dcf_regs i_dcf_regs (.clk_in, .rst_in, .standby_power_on_reset_in, .s_awaddr_in,
        .s_awvalid_in, .s_awready_out, .s_wdata_in, .s_wstrb_in, .s_wvalid_in, .s_wready_out,
        .s_bresp_out, .s_bvalid_out, .s_bready_in, .s_araddr_in, .s_arvalid_in, .s_arready_out,
        .s_rdata_out, .s_rresp_out, .s_rvalid_out, .s_rready_in, .step_pulse_n_in,
        .drive0_select_n_in, .drive1_select_n_in, .disk_changed_in_n_in, .rate_wr_in,
        .rate_data_in, .fifo_ctrl_wr_in, .fifo_ctrl_data_in, .disk_change_flag_out,
        .force_state_out);
    dcf_floppy_model i_dcf_floppy_model (.clk_in, .step_n_out(step_pulse_n_in),
        .sel0_n_out(drive0_select_n_in), .sel1_n_out(drive1_select_n_in),
        .changed_n_out(disk_changed_in_n_in), .rate_wr_out(rate_wr_in),
        .rate_data_out(rate_data_in));
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    function automatic logic [1:0] resp_of(input logic [DCF_ADDR_W-1:0] a);
        return (a inside {DCF_ADDR_FORCE, DCF_ADDR_RATE, DCF_ADDR_FIFO}) ? DCF_RESP_OKAY
            : DCF_RESP_SLVERR;
    endfunction
    task automatic wchk(input logic [DCF_ADDR_W-1:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'hf);
        s_awaddr_in <= a;
        s_wdata_in <= d;
        s_wstrb_in <= s;
        s_awvalid_in <= 1'b1;
        s_wvalid_in <= 1'b1;
        s_bready_in <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_awvalid_in && s_awready_out) s_awvalid_in <= 1'b0;
            if (s_wvalid_in && s_wready_out) s_wvalid_in <= 1'b0;
        end while (!s_bvalid_out);
        `CHK(s_bresp_out, resp_of(a))
        s_bready_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rchk(input logic [DCF_ADDR_W-1:0] a, input logic [31:0] e);
        s_araddr_in <= a;
        s_arvalid_in <= 1'b1;
        s_rready_in <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_arvalid_in && s_arready_out) s_arvalid_in <= 1'b0;
        end while (!s_rvalid_out);
        `CHK(s_rdata_out, e)
        `CHK(s_rresp_out, resp_of(a))
        s_rready_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rchk(DCF_ADDR_FORCE, 32'h3);
        rchk(DCF_ADDR_RATE, 32'h2);
        rchk(DCF_ADDR_FIFO, 32'h0);
        `CHK(disk_change_flag_out, 1'b0)
        i_dcf_floppy_model.select(0, 1'b1);
        `CHK(disk_change_flag_out, 1'b1)
        i_dcf_floppy_model.step(1);
        `CHK(force_state_out, 2'h2)
        `CHK(disk_change_flag_out, 1'b0)
        i_dcf_floppy_model.select(0, 1'b0);
        i_dcf_floppy_model.select(1, 1'b1);
        `CHK(disk_change_flag_out, 1'b1)
        i_dcf_floppy_model.step(4);
        `CHK(force_state_out, 2'h0)
        i_dcf_floppy_model.select(1, 1'b0);
        wchk(DCF_ADDR_FORCE, 32'h3, 4'he);
        rchk(DCF_ADDR_FORCE, 32'h0);
        wchk(DCF_ADDR_FORCE, 32'hfd);
        rchk(DCF_ADDR_FORCE, 32'h1);
        wchk(DCF_ADDR_FORCE, 32'h2);
        rchk(DCF_ADDR_FORCE, 32'h3);
        wchk(DCF_ADDR_FORCE, 32'h0);
        rchk(DCF_ADDR_FORCE, 32'h3);
        i_dcf_floppy_model.media(1'b1);
        `CHK(disk_change_flag_out, 1'b1)
        i_dcf_floppy_model.media(1'b0);
        foreach (pats[i]) begin
            i_dcf_floppy_model.rate(pats[i]);
            @(posedge clk_in);
            fifo_ctrl_wr_in <= 1'b1;
            fifo_ctrl_data_in <= pats[i];
            @(posedge clk_in);
            fifo_ctrl_wr_in <= 1'b0;
            fifo_ctrl_data_in <= ~pats[i];
            rchk(DCF_ADDR_RATE, {24'h0, pats[i] & 8'hdf});
            rchk(DCF_ADDR_FIFO, {24'h0, pats[i] & 8'hcf});
        end
        wchk(DCF_ADDR_RATE, 32'h0);
        rchk(DCF_ADDR_RATE, 32'h85);
        wchk(8'h04, 32'h1);
        rchk(8'h04, 32'h0);
        @(posedge clk_in);
        standby_power_on_reset_in <= 1'b1;
        @(posedge clk_in);
        standby_power_on_reset_in <= 1'b0;
        rchk(DCF_ADDR_RATE, 32'h2);
        rchk(DCF_ADDR_FORCE, 32'h3);
        i_dcf_floppy_model.rate(8'h5a);
        i_dcf_floppy_model.select(0, 1'b1);
        i_dcf_floppy_model.step(2);
        i_dcf_floppy_model.select(0, 1'b0);
        `CHK(force_state_out, 2'h2)
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rchk(DCF_ADDR_FORCE, 32'h3);
        rchk(DCF_ADDR_RATE, 32'h2);
        give_verdict();
    end
endmodule
